// *** logic/fuse_check_pkg.sv ***
/*
 constants and types for the test-port fuse check control.
 assumes one 25 MHz clock and synchronous pin inputs.
*/
package fuse_check_pkg;
   localparam int clk_period_ns = 40;
   localparam logic [1:0] rise_count_zero = 2'h0;
   localparam logic [1:0] rise_count_one = 2'h1;
   localparam logic [1:0] rise_count_off = 2'h2;
   localparam logic select_idle_level = 1'h1;
   localparam logic check_mode_reset = 1'h0;
   localparam logic pin_out_reset = 1'h0;
   localparam logic pin_oe_n_reset = 1'h1;
   localparam logic pin_is_input_reset = 1'h1;
   typedef enum logic [1:0]
   {
      st_start = 2'b00,
      st_idle = 2'b01,
      st_armed = 2'b10,
      st_done = 2'b11
   } fuse_state_t;
endpackage

// *** logic/fuse_check_ctrl.sv ***
/*
 test-port fuse check mode control: arms, disarms and gates the check current,
 and sets the direction of the shared data-out/data-in pin.
 assumes the pin inputs are synchronous to ref_clk_in and that the only reset
 is power-on reset on rst_n_in.
*/
`timescale 1ns/1ns
module fuse_check_ctrl
   import fuse_check_pkg::*;
(
   input wire logic ref_clk_in,
   input wire logic rst_n_in,
   input wire logic fuse_on_data_in_in,
   input wire logic mode_select_in,
   input wire logic programming_in,
   input wire logic data_out_value_in,
   input wire logic data_out_active_in,
   output logic check_mode_out,
   output logic check_current_en_out,
   output logic shared_pin_out,
   output logic shared_pin_oe_n_out,
   output logic shared_pin_is_input_out
);

   // state, edge count and edge strobes
   fuse_state_t state;
   fuse_state_t next_state;
   logic [1:0] rise_count;
   logic [1:0] next_rise_count;
   logic select_prev;
   logic power_up_pass;
   logic rise_seen;
   logic fall_seen;
   logic second_rise;

   // next values of the registered outputs
   logic next_check_mode;
   logic next_pin_is_input;

   // previous mode-select level, idle high out of reset,
   // so a pin high at release is not a rise; a low pin is the held-low case
   always_ff @(posedge ref_clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         select_prev <= select_idle_level;
      end
      else
      begin
         select_prev <= mode_select_in;
      end
   end

   // the power-up pass samples the level, so edges count only after it
   always_comb
   begin
      power_up_pass = (state == st_start);
      rise_seen = 1'h0;
      fall_seen = 1'h0;
      if (!power_up_pass)
      begin
         rise_seen = mode_select_in && !select_prev;
         fall_seen = !mode_select_in && select_prev;
      end
   end

   // the disarming edge is the one that finds one rise already counted
   assign second_rise = rise_seen && (rise_count == rise_count_one);

   // rising edges counted from power-up, saturating at the disarm count
   always_comb
   begin
      next_rise_count = rise_count;
      if (rise_seen && (rise_count != rise_count_off))
      begin
         next_rise_count = rise_count + rise_count_one;
      end
   end

   always_ff @(posedge ref_clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         rise_count <= rise_count_zero;
      end
      else
      begin
         rise_count <= next_rise_count;
      end
   end

   // mode sequence: power-up pass, idle, armed, then done until power-on
   always_comb
   begin
      next_state = state;
      unique case (state)
         st_start:
         begin
            // power-up pass samples the variant and the held-low case
            if (!fuse_on_data_in_in)
            begin
               next_state = st_done;
            end
            else if (!mode_select_in)
            begin
               next_state = st_armed;
            end
            else
            begin
               next_state = st_idle;
            end
         end
         st_idle:
         begin
            if (second_rise)
            begin
               next_state = st_done;
            end
            else if (fall_seen)
            begin
               next_state = st_armed;
            end
         end
         st_armed:
         begin
            if (second_rise)
            begin
               next_state = st_done;
            end
         end
         st_done:
         begin
            next_state = st_done;
         end
      endcase
   end

   // power-on reset is the only way back to the power-up pass
   always_ff @(posedge ref_clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         state <= st_start;
      end
      else
      begin
         state <= next_state;
      end
   end

   // mode flag from a flip-flop, in step with the state register
   assign next_check_mode = (next_state == st_armed);

   always_ff @(posedge ref_clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         check_mode_out <= check_mode_reset;
      end
      else
      begin
         check_mode_out <= next_check_mode;
      end
   end

   // combinational so the current stops in the cycle the pin goes high
   // and never flows once the mode is left
   always_comb
   begin
      check_current_en_out = 1'h0;
      if (check_mode_out && !mode_select_in)
      begin
         check_current_en_out = 1'h1;
      end
   end

   // shared pin is an input while programming or when test logic is quiet
   always_comb
   begin
      next_pin_is_input = !data_out_active_in;
      if (programming_in)
      begin
         next_pin_is_input = 1'h1;
      end
   end

   // data to the shared pin, launched from a flip-flop
   always_ff @(posedge ref_clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         shared_pin_out <= pin_out_reset;
      end
      else
      begin
         shared_pin_out <= data_out_value_in;
      end
   end

   // output enable, low while the pin is driven
   always_ff @(posedge ref_clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         shared_pin_oe_n_out <= pin_oe_n_reset;
      end
      else
      begin
         shared_pin_oe_n_out <= next_pin_is_input;
      end
   end

   // direction flag, high while the pin serves as test data input
   always_ff @(posedge ref_clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         shared_pin_is_input_out <= pin_is_input_reset;
      end
      else
      begin
         shared_pin_is_input_out <= next_pin_is_input;
      end
   end
endmodule

// *** dv/fuse_check_host.sv ***
/* programmer model: drives the mode pin. assumes the bench calls drive */
`timescale 1ns/1ns
module fuse_check_host
(
   input wire logic ref_clk_in,
   output logic mode_select_out
);
   initial mode_select_out = 1'h1;
   task automatic drive(input logic v, input int n);
      @(negedge ref_clk_in) mode_select_out = v;
      repeat (n) @(negedge ref_clk_in);
   endtask
endmodule

// *** dv/fuse_check_ctrl_chk.sv ***
/* fuse check assertions. assumes one clock and async low reset */
`timescale 1ns/1ns
module fuse_check_chk
(
   input wire logic ref_clk_in,
   input wire logic rst_n_in,
   input wire logic fuse_on_data_in_in,
   input wire logic mode_select_in,
   input wire logic programming_in,
   input wire logic data_out_value_in,
   input wire logic check_mode_out,
   input wire logic check_current_en_out,
   input wire logic shared_pin_out,
   input wire logic shared_pin_oe_n_out,
   input wire logic shared_pin_is_input_out
);
   logic was_armed;
   logic was_disarmed;
   default clocking @(posedge ref_clk_in); endclocking
   default disable iff (!rst_n_in);
   always_ff @(posedge ref_clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         was_armed <= 1'h0;
         was_disarmed <= 1'h0;
      end
      else
      begin
         was_armed <= was_armed || check_mode_out;
         was_disarmed <= was_disarmed || (was_armed && !check_mode_out);
      end
   end
   chk_no_rearm: assert property (
      was_disarmed |-> !check_mode_out) else $error("mode active again after disarm");
   chk_current_gate: assert property (
      check_current_en_out == (check_mode_out & !mode_select_in)) else $error("gate");
   chk_arm_low: assert property (
      $rose(check_mode_out) |-> !$past(mode_select_in)) else $error("arm");
   chk_arm_fuse: assert property (
      $rose(check_mode_out) |-> fuse_on_data_in_in) else $error("fuse");
   chk_disarm_rise: assert property (
      $fell(check_mode_out) |-> $past(mode_select_in)) else $error("disarm");
   chk_stay_off: assert property (
      $fell(check_mode_out) |-> !check_mode_out[*8]) else $error("rearm");
   chk_dir_pair: assert property (
      shared_pin_oe_n_out == shared_pin_is_input_out) else $error("dir");
   chk_prog_input: assert property (
      $past(programming_in) |-> shared_pin_is_input_out) else $error("prog");
   chk_drive_value: assert property (
      !shared_pin_oe_n_out |-> shared_pin_out == $past(data_out_value_in)) else $error("val");
   cover property ($rose(check_mode_out));
   cover property ($fell(check_mode_out));
   cover property (!shared_pin_oe_n_out);
   cover property (check_current_en_out);
endmodule
bind fuse_check_ctrl fuse_check_chk u_chk(
   .ref_clk_in(ref_clk_in),
   .rst_n_in(rst_n_in),
   .fuse_on_data_in_in(fuse_on_data_in_in),
   .mode_select_in(mode_select_in),
   .programming_in(programming_in),
   .data_out_value_in(data_out_value_in),
   .check_mode_out(check_mode_out),
   .check_current_en_out(check_current_en_out),
   .shared_pin_out(shared_pin_out),
   .shared_pin_oe_n_out(shared_pin_oe_n_out),
   .shared_pin_is_input_out(shared_pin_is_input_out)
);

// *** dv/testbench.sv ***
/* bench: host model drives the mode pin. assumes the design package is compiled */
`timescale 1ns/1ns
module testbench;
   logic ref_clk_in = 0, rst_n_in = 0, fuse_on_data_in_in = 1, programming_in = 0;
   logic data_out_value_in = 0, data_out_active_in = 0, mode_select_in, check_mode_out;
   logic check_current_en_out, shared_pin_out, shared_pin_oe_n_out, shared_pin_is_input_out;
   int n_fail = 0, samples_checked = 0;
   wire [1:0] mc = {check_mode_out, check_current_en_out};
   always #(fuse_check_pkg::clk_period_ns / 2) ref_clk_in = ~ref_clk_in;
   fuse_check_host u_host(.ref_clk_in(ref_clk_in), .mode_select_out(mode_select_in));
   fuse_check_ctrl u_dut(
      .ref_clk_in(ref_clk_in),
      .rst_n_in(rst_n_in),
      .fuse_on_data_in_in(fuse_on_data_in_in),
      .mode_select_in(mode_select_in),
      .programming_in(programming_in),
      .data_out_value_in(data_out_value_in),
      .data_out_active_in(data_out_active_in),
      .check_mode_out(check_mode_out),
      .check_current_en_out(check_current_en_out),
      .shared_pin_out(shared_pin_out),
      .shared_pin_oe_n_out(shared_pin_oe_n_out),
      .shared_pin_is_input_out(shared_pin_is_input_out)
   );
   task automatic chk(input logic [1:0] s, e);
      samples_checked++;
      if (s !== e)
      begin
         n_fail++;
         $display("FAIL %0t %h %h", $time, s, e);
      end
   endtask
   task automatic por(input logic lvl, f);
      rst_n_in = 0;
      fuse_on_data_in_in = f;
      u_host.drive(lvl, 3);
      rst_n_in = 1;
      u_host.drive(lvl, 2);
   endtask
   task automatic t_edges;
      por(1, 1);
      chk(mc, 2'h0);
      u_host.drive(0, 2);
      chk(mc, 2'h3);
      u_host.drive(1, 2);
      chk(mc, 2'h2);
      u_host.drive(0, 2);
      u_host.drive(1, 2);
      chk(mc, 2'h0);
      u_host.drive(0, 2);
      chk(mc, 2'h0);
   endtask
   task automatic t_held;
      por(0, 1);
      chk(mc, 2'h3);
      rst_n_in = 0;
      #1 chk(mc, 2'h0);
      por(0, 0);
      chk(mc, 2'h0);
   endtask
   task automatic t_pin;
      {programming_in, data_out_active_in, data_out_value_in} = 3'h7;
      u_host.drive(1, 2);
      chk({shared_pin_oe_n_out, shared_pin_is_input_out}, 2'h3);
      programming_in = 0;
      u_host.drive(1, 2);
      chk({shared_pin_oe_n_out, shared_pin_out}, 2'h1);
      data_out_active_in = 0;
      u_host.drive(1, 2);
      chk({shared_pin_oe_n_out, shared_pin_is_input_out}, 2'h3);
   endtask
   task automatic close_out;
      $display("checks %0d fails %0d", samples_checked, n_fail);
      if (n_fail == 0 && samples_checked > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   initial
   begin
      t_edges;
      t_held;
      t_pin;
      close_out;
   end
endmodule
